// ### verilog/lglc_regs.vh
// Register map, field positions, reset values and timing counts of the line global config block
`ifndef LGLC_REGS_VH
`define LGLC_REGS_VH

// Register indices; the byte address is four times the index
`define LGLC_IDX_CTRL_ONE 16'h0fe2
`define LGLC_IDX_CTRL_TWO 16'h0fe3
`define LGLC_IDX_CTRL_THREE 16'h0fe4
`define LGLC_IDX_STATUS 16'h0fe6
`define LGLC_ADDR_W 16

// Control one fields
`define LGLC_GAUGE_LSB 4
`define LGLC_MUTE_BIT 2
`define LGLC_EXTENDED_LOS_THRESHOLD_BIT 1
`define LGLC_ICT_BIT 0
`define LGLC_CTRL_ONE_MASK 8'h37
`define LGLC_CTRL_ONE_RST 8'h00

// Control two fields
`define LGLC_TERM_SRC_BIT 6
`define LGLC_CTRL_TWO_MASK 8'h40
`define LGLC_CTRL_TWO_RST 8'h00

// Control three fields
`define LGLC_T1_RATE_LSB 6
`define LGLC_E1_RATE_LSB 4
`define LGLC_CTRL_THREE_MASK 8'hf0
`define LGLC_CTRL_THREE_RST 8'h00

// Gauge codes
`define LGLC_GAUGE_22_24 2'h0
`define LGLC_GAUGE_22 2'h1
`define LGLC_GAUGE_24 2'h2
`define LGLC_GAUGE_26 2'h3

// Loss-of-signal zero run lengths
`define LGLC_LOS_ZEROS_STD 13'h00af
`define LGLC_LOS_ZEROS_EXT 13'h1000

// Phase increments for a 250 MHz clock: rate * 2^32 / 250 MHz
`define LGLC_INC_T1_1544 32'h0194_c016
`define LGLC_INC_T1_3088 32'h0329_802c
`define LGLC_INC_T1_6176 32'h0653_0058
`define LGLC_INC_T1_12352 32'h0ca6_00b0
`define LGLC_INC_E1_2048 32'h0218_def4
`define LGLC_INC_E1_4096 32'h0431_bde8
`define LGLC_INC_E1_8192 32'h0863_7bd0
`define LGLC_INC_E1_16384 32'h10c6_f7a0

// AXI responses
`define LGLC_RESP_OKAY 2'h0
`define LGLC_RESP_SLVERR 2'h2

`endif

// ### verilog/lglc_los_detect.v
// Consecutive-zero loss-of-signal detector for one receive channel
`timescale 1ns/100ps
`include "lglc_regs.vh"

module lglc_los_detect (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Receive line bits
    input wire bit_valid,
    input wire bit_in,
    // Threshold select
    input wire extended_los_threshold,
    // Detector state
    output reg recv_loss_of_signal
);

reg [12:0] zero_run;
wire [12:0] limit;
wire [12:0] next_run;

// R4 R5 threshold select
assign limit = extended_los_threshold ? `LGLC_LOS_ZEROS_EXT : `LGLC_LOS_ZEROS_STD;
assign next_run = (zero_run < limit) ? zero_run + 13'h0001 : zero_run;

always @(posedge clk) begin
    if (sys_rst) begin
        zero_run <= 13'h0000;
        recv_loss_of_signal <= 1'b0;
    end else if (bit_valid) begin
        if (bit_in) begin
            zero_run <= 13'h0000;
            recv_loss_of_signal <= 1'b0;
        end else begin
            zero_run <= next_run;
            // R4 R5 declare on count
            recv_loss_of_signal <= (next_run >= limit);
        end
    end else begin
        recv_loss_of_signal <= recv_loss_of_signal | (zero_run >= limit);
    end
end

endmodule // lglc_los_detect

// ### verilog/lglc_clock_synth.v
// Phase-accumulator clock synthesiser for a programmable master clock output
`timescale 1ns/100ps

module lglc_clock_synth (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Phase step per system clock
    input wire [31:0] phase_inc,
    // Synthesised clock
    output reg clock_out
);

reg [31:0] phase_acc;

always @(posedge clk) begin
    if (sys_rst) begin
        phase_acc <= 32'h0000_0000;
        clock_out <= 1'b0;
    end else begin
        phase_acc <= phase_acc + phase_inc;
        clock_out <= phase_acc[31];
    end
end

endmodule // lglc_clock_synth

// ### verilog/lglc_top.v
// Line interface global configuration registers with AXI4-Lite access
//
// Contract
// R1 - The two-bit gauge field in bits 5:4 selects the line wire size, 00 by default.
// R2 - With muting on, recovered data toward the framer is forced low while loss of signal holds.
// R3 - The recovered receive clock keeps running while data is muted.
// R4 - With extended loss of signal on, loss is declared after 4096 consecutive zeros.
// R5 - With extended loss of signal off, loss is declared after 175 consecutive zeros.
// R6 - The in-circuit-test bit tristates every output pin of all channels, cleared by default.
// R7 - The termination source bit picks register bit (0) or hardware pin (1), 0 by default.
// R8 - Bits 7:6 set the T1 master clock to 1.544, 3.088, 6.176 or 12.352 MHz.
// R9 - Bits 5:4 set the E1 master clock to 2.048, 4.096, 8.192 or 16.384 MHz.
// R10 - Software writes zero to the top termination bit and reserved bits, which read as zero.
`timescale 1ns/100ps
`include "lglc_regs.vh"

module lglc_top (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // AXI4-Lite write address
    input wire [15:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [15:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Receive line bits per channel
    input wire [1:0] rx_line_bit,
    input wire [1:0] rx_line_bit_valid,
    input wire [1:0] rx_recovered_clock,
    // Termination selection sources
    input wire [1:0] recv_termination_choice,
    input wire recv_termination_pin,
    // Toward the framer
    output reg [1:0] rx_data_to_framer,
    output reg [1:0] rx_clock_to_framer,
    output reg [1:0] recv_loss_of_signal,
    // Line configuration
    output reg [1:0] line_gauge_sel,
    output reg [1:0] recv_termination_sel,
    // Master clock outputs
    output reg t1_master_clock_out,
    output reg e1_master_clock_out,
    // Output enable for every device pin
    output reg pin_output_enable
);

// Address decode shared by both paths
localparam [2:0] SEL_NONE = 3'd0;
localparam [2:0] SEL_ONE = 3'd1;
localparam [2:0] SEL_TWO = 3'd2;
localparam [2:0] SEL_THREE = 3'd3;
localparam [2:0] SEL_STATUS = 3'd4;

function [2:0] decode_addr;
    input [15:0] addr;
    begin
        if (addr[1:0] != 2'b00) begin
            decode_addr = SEL_NONE;
        end else begin
            case ({2'b00, addr[15:2]})
                `LGLC_IDX_CTRL_ONE: decode_addr = SEL_ONE;
                `LGLC_IDX_CTRL_TWO: decode_addr = SEL_TWO;
                `LGLC_IDX_CTRL_THREE: decode_addr = SEL_THREE;
                `LGLC_IDX_STATUS: decode_addr = SEL_STATUS;
                default: decode_addr = SEL_NONE;
            endcase
        end
    end
endfunction

// Register contents
reg [7:0] line_global_control_one;
reg [7:0] line_global_control_two;
reg [7:0] line_global_control_three;

// Write path state
reg aw_held;
reg w_held;
reg [15:0] aw_addr_q;
reg [7:0] w_byte_q;
reg w_lane_q;
reg next_aw_held;
reg next_w_held;
reg next_bvalid;
reg do_write;
reg [15:0] wr_addr;
reg [7:0] wr_byte;
reg wr_lane;
reg [2:0] wr_sel;

wire aw_hs;
wire w_hs;
wire b_hs;
wire ar_hs;
wire r_hs;

assign aw_hs = s_axi_awvalid & s_axi_awready;
assign w_hs = s_axi_wvalid & s_axi_wready;
assign b_hs = s_axi_bvalid & s_axi_bready;
assign ar_hs = s_axi_arvalid & s_axi_arready;
assign r_hs = s_axi_rvalid & s_axi_rready;

// Configuration fields
wire mute_enable;
wire extended_los_threshold;
wire incircuit_test_tristate;
wire recv_termination_source;
wire [1:0] t1_master_clock_rate_sel;
wire [1:0] e1_master_clock_rate_sel;

assign mute_enable = line_global_control_one[`LGLC_MUTE_BIT];
assign extended_los_threshold = line_global_control_one[`LGLC_EXTENDED_LOS_THRESHOLD_BIT];
assign incircuit_test_tristate = line_global_control_one[`LGLC_ICT_BIT];
assign recv_termination_source = line_global_control_two[`LGLC_TERM_SRC_BIT];
assign t1_master_clock_rate_sel = line_global_control_three[`LGLC_T1_RATE_LSB +: 2];
assign e1_master_clock_rate_sel = line_global_control_three[`LGLC_E1_RATE_LSB +: 2];

// Write channel combining: address and data may arrive in either order
always @* begin
    wr_addr = aw_hs ? s_axi_awaddr : aw_addr_q;
    wr_byte = w_hs ? s_axi_wdata[7:0] : w_byte_q;
    wr_lane = w_hs ? s_axi_wstrb[0] : w_lane_q;
    wr_sel = decode_addr(wr_addr);
    do_write = (aw_held | aw_hs) & (w_held | w_hs);
    next_aw_held = (aw_held | aw_hs) & ~do_write;
    next_w_held = (w_held | w_hs) & ~do_write;
    next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
end

always @(posedge clk) begin
    if (sys_rst) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr_q <= 16'h0000;
        w_byte_q <= 8'h00;
        w_lane_q <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `LGLC_RESP_OKAY;
    end else begin
        aw_held <= next_aw_held;
        w_held <= next_w_held;
        if (aw_hs) begin
            aw_addr_q <= s_axi_awaddr;
        end
        if (w_hs) begin
            w_byte_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
        end
        s_axi_awready <= ~next_aw_held & ~next_bvalid;
        s_axi_wready <= ~next_w_held & ~next_bvalid;
        s_axi_bvalid <= next_bvalid;
        if (do_write) begin
            s_axi_bresp <= (wr_sel == SEL_NONE) ? `LGLC_RESP_SLVERR : `LGLC_RESP_OKAY;
        end else if (b_hs) begin
            s_axi_bresp <= `LGLC_RESP_OKAY;
        end
    end
end

// Register storage; undefined bits are never stored
always @(posedge clk) begin
    if (sys_rst) begin
        // R1 R6 R7 defaults
        line_global_control_one <= `LGLC_CTRL_ONE_RST;
        line_global_control_two <= `LGLC_CTRL_TWO_RST;
        line_global_control_three <= `LGLC_CTRL_THREE_RST;
    end else if (do_write && wr_lane) begin
        case (wr_sel)
            SEL_ONE: begin
                line_global_control_one <= wr_byte & `LGLC_CTRL_ONE_MASK;
            end
            // R10 forced bit dropped
            SEL_TWO: begin
                line_global_control_two <= wr_byte & `LGLC_CTRL_TWO_MASK;
            end
            SEL_THREE: begin
                line_global_control_three <= wr_byte & `LGLC_CTRL_THREE_MASK;
            end
            default: begin
                line_global_control_one <= line_global_control_one;
            end
        endcase
    end
end

// Read channel
reg [31:0] read_word;
reg [2:0] rd_sel;

always @* begin
    rd_sel = decode_addr(s_axi_araddr);
    // R10 reserved read zero
    case (rd_sel)
        SEL_ONE: read_word = {24'h00_0000, line_global_control_one};
        SEL_TWO: read_word = {24'h00_0000, line_global_control_two};
        SEL_THREE: read_word = {24'h00_0000, line_global_control_three};
        SEL_STATUS: read_word = {30'h0000_0000, recv_loss_of_signal};
        default: read_word = 32'h0000_0000;
    endcase
end

always @(posedge clk) begin
    if (sys_rst) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `LGLC_RESP_OKAY;
    end else if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word;
        s_axi_rresp <= (rd_sel == SEL_NONE) ? `LGLC_RESP_SLVERR : `LGLC_RESP_OKAY;
    end else if (r_hs) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `LGLC_RESP_OKAY;
    end else begin
        s_axi_arready <= ~s_axi_rvalid;
    end
end

// Loss-of-signal detection per channel
wire [1:0] los_now;

lglc_los_detect u_los_ch0 (
    .clk(clk),
    .sys_rst(sys_rst),
    .bit_valid(rx_line_bit_valid[0]),
    .bit_in(rx_line_bit[0]),
    .extended_los_threshold(extended_los_threshold),
    .recv_loss_of_signal(los_now[0])
);

lglc_los_detect u_los_ch1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .bit_valid(rx_line_bit_valid[1]),
    .bit_in(rx_line_bit[1]),
    .extended_los_threshold(extended_los_threshold),
    .recv_loss_of_signal(los_now[1])
);

// Receive path toward the framer
always @(posedge clk) begin
    if (sys_rst) begin
        rx_data_to_framer <= 2'b00;
        rx_clock_to_framer <= 2'b00;
        recv_loss_of_signal <= 2'b00;
    end else begin
        // R2 mute on loss
        rx_data_to_framer <= rx_line_bit & ~({2{mute_enable}} & los_now);
        // R3 clock never muted
        rx_clock_to_framer <= rx_recovered_clock;
        recv_loss_of_signal <= los_now;
    end
end

// Line configuration outputs
always @(posedge clk) begin
    if (sys_rst) begin
        line_gauge_sel <= `LGLC_GAUGE_22_24;
        recv_termination_sel <= 2'b00;
        pin_output_enable <= 1'b0;
    end else begin
        // R1 gauge select
        line_gauge_sel <= line_global_control_one[`LGLC_GAUGE_LSB +: 2];
        // R7 termination source
        recv_termination_sel <= recv_termination_source ?
            {2{recv_termination_pin}} : recv_termination_choice;
        // R6 tristate all pins
        pin_output_enable <= ~incircuit_test_tristate;
    end
end

// Master clock rate tables
function [31:0] t1_phase_step;
    input [1:0] sel;
    begin
        case (sel)
            2'b00: t1_phase_step = `LGLC_INC_T1_1544;
            2'b01: t1_phase_step = `LGLC_INC_T1_3088;
            2'b10: t1_phase_step = `LGLC_INC_T1_6176;
            default: t1_phase_step = `LGLC_INC_T1_12352;
        endcase
    end
endfunction

function [31:0] e1_phase_step;
    input [1:0] sel;
    begin
        case (sel)
            2'b00: e1_phase_step = `LGLC_INC_E1_2048;
            2'b01: e1_phase_step = `LGLC_INC_E1_4096;
            2'b10: e1_phase_step = `LGLC_INC_E1_8192;
            default: e1_phase_step = `LGLC_INC_E1_16384;
        endcase
    end
endfunction

wire t1_synth;
wire e1_synth;

// R8 T1 clock rate
lglc_clock_synth u_t1_clk (
    .clk(clk),
    .sys_rst(sys_rst),
    .phase_inc(t1_phase_step(t1_master_clock_rate_sel)),
    .clock_out(t1_synth)
);

// R9 E1 clock rate
lglc_clock_synth u_e1_clk (
    .clk(clk),
    .sys_rst(sys_rst),
    .phase_inc(e1_phase_step(e1_master_clock_rate_sel)),
    .clock_out(e1_synth)
);

always @(posedge clk) begin
    if (sys_rst) begin
        t1_master_clock_out <= 1'b0;
        e1_master_clock_out <= 1'b0;
    end else begin
        t1_master_clock_out <= t1_synth;
        e1_master_clock_out <= e1_synth;
    end
end

endmodule // lglc_top

// ### verification/lglc_top_sva.sv
// Port-level assertions for the line global config block
`timescale 1ns/100ps

module lglc_top_sva (
    // Clock and reset
    input logic clk,
    input logic sys_rst,
    // Register bus handshakes
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic [31:0] s_axi_rdata,
    // Receive path
    input logic [1:0] rx_line_bit,
    input logic [1:0] rx_line_bit_valid,
    input logic [1:0] rx_recovered_clock,
    input logic [1:0] rx_data_to_framer,
    input logic [1:0] rx_clock_to_framer,
    input logic [1:0] recv_loss_of_signal,
    // Master clocks
    input logic t1_master_clock_out,
    input logic e1_master_clock_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    wire [1:0] zero_seen = rx_line_bit_valid & ~rx_line_bit;
    wire [1:0] one_seen = rx_line_bit_valid & rx_line_bit;

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write response missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    a_reserved_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
    a_clock_unmuted: assert property (
        !$past(sys_rst) |-> rx_clock_to_framer == $past(rx_recovered_clock))
        else $error("receive clock not passed");
    a_data_from_line: assert property (
        !$past(sys_rst) && rx_data_to_framer[0] |-> $past(rx_line_bit[0]))
        else $error("framer data not from line");
    a_los_on_zero: assert property (
        $rose(recv_loss_of_signal[0]) |-> $past(zero_seen[0], 2))
        else $error("loss declared without zero bit");
    a_los_on_one: assert property (
        $fell(recv_loss_of_signal[0]) |-> $past(one_seen[0], 2))
        else $error("loss cleared without one bit");
    a_los_ch_one: assert property (
        $rose(recv_loss_of_signal[1]) |-> $past(zero_seen[1], 2))
        else $error("channel one loss without zero bit");
    a_t1_running: assert property (
        $rose(t1_master_clock_out) |-> ##[1:170] $rose(t1_master_clock_out))
        else $error("master clock stalled");
    a_e1_running: assert property (
        $rose(e1_master_clock_out) |-> ##[1:130] $rose(e1_master_clock_out))
        else $error("e1 master clock stalled");
endmodule // lglc_top_sva

bind lglc_top lglc_top_sva lglc_top_sva_inst (.*);

// ### verification/lglc_top_bench.sv
// Self-checking testbench for the line global config block
`timescale 1ns/100ps
`include "lglc_regs.vh"

module lglc_top_bench;
    localparam [15:0] a_one = `LGLC_IDX_CTRL_ONE << 2;
    localparam [15:0] a_two = `LGLC_IDX_CTRL_TWO << 2;
    localparam [15:0] a_three = `LGLC_IDX_CTRL_THREE << 2;
    localparam [15:0] a_stat = `LGLC_IDX_STATUS << 2;
    localparam [1:0] ok = `LGLC_RESP_OKAY;
    localparam [1:0] err = `LGLC_RESP_SLVERR;
    integer err_total = 0;
    integer n_compared = 0;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [15:0] s_axi_awaddr = 16'h0000;
    reg [15:0] s_axi_araddr = 16'h0000;
    reg [31:0] s_axi_wdata = 32'h0000_0000;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, recv_termination_pin = 1'b0;
    reg [1:0] rx_line_bit = 2'h0, rx_line_bit_valid = 2'h0;
    reg [1:0] rx_recovered_clock = 2'h1, recv_termination_choice = 2'h0;
    wire [2:0] s_axi_awprot = 3'h0;
    wire [2:0] s_axi_arprot = 3'h0;
    reg [3:0] s_axi_wstrb = 4'h1;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire t1_master_clock_out, e1_master_clock_out, pin_output_enable;
    wire [1:0] s_axi_bresp, s_axi_rresp, rx_data_to_framer, rx_clock_to_framer;
    wire [1:0] recv_loss_of_signal, line_gauge_sel, recv_termination_sel;
    wire [31:0] s_axi_rdata;

    lglc_top lglc_top_inst (.*);

    always #2 clk = ~clk;
    always @(posedge clk) rx_recovered_clock <= ~rx_recovered_clock;

    task chk(input [31:0] seen, input [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task settle(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task done(input string s);
        $display("test %0s done", s);
    endtask

    task wr(input [15:0] a, input [7:0] d, input [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er); // write response
    endtask

    task rd(input [15:0] a, input [7:0] ed, input [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h00_0000, ed}); // read data
        chk(s_axi_rresp, er); // read response
    endtask

    task send(input integer n, input [1:0] b);
        repeat (n) begin
            @(posedge clk);
            rx_line_bit <= b;
            rx_line_bit_valid <= 2'h3;
            @(posedge clk);
            rx_line_bit_valid <= 2'h0;
        end
    endtask

    task t_regs;
        rd(a_one, 8'h00, ok); // default
        rd(a_two, 8'h00, ok); // default
        rd(a_three, 8'h00, ok); // default
        chk(pin_output_enable, 1'b1); // default
        wr(a_one, 8'h37, ok); // zero reserved bits
        rd(a_one, 8'h37, ok); // masked bits
        chk(pin_output_enable, 1'b0); // tristate
        wr(a_one, 8'h00, ok);
        settle(1);
        chk(pin_output_enable, 1'b1); // resume
        wr(a_two, 8'h40, ok); // zero top bit
        rd(a_two, 8'h40, ok); // masked bits
        s_axi_wstrb <= 4'h0;
        wr(a_two, 8'h00, ok); // lane off ignored
        s_axi_wstrb <= 4'h1;
        rd(a_two, 8'h40, ok); // value kept
        wr(a_three, 8'hf0, ok); // zero reserved bits
        rd(a_three, 8'hf0, ok); // masked bits
        wr(a_stat, 8'hff, ok);
        rd(a_stat, 8'h00, ok); // no loss
        wr(16'h0000, 8'h12, err);
        rd(16'h0000, 8'h00, err);
        rd(a_one + 16'h0001, 8'h00, err);
        done("registers");
    endtask

    task t_gauge;
        for (int g = 0; g < 4; g++) begin
            wr(a_one, 8'(g * 16), ok);
            settle(1);
            chk(line_gauge_sel, g[1:0]); // gauge code
            rd(a_one, 8'(g * 16), ok); // readback
        end
        done("gauge");
    endtask

    task t_term;
        recv_termination_choice <= 2'h2;
        recv_termination_pin <= 1'b1;
        wr(a_two, 8'h00, ok);
        settle(2);
        chk(recv_termination_sel, 2'h2); // register source
        wr(a_two, 8'h40, ok);
        settle(2);
        chk(recv_termination_sel, 2'h3); // pin source
        @(posedge clk);
        recv_termination_pin <= 1'b0;
        settle(2);
        chk(recv_termination_sel, 2'h0); // pin follows
        done("termination");
    endtask

    task t_los;
        wr(a_one, 8'h04, ok);
        send(174, 2'h0);
        settle(2);
        chk(recv_loss_of_signal, 2'h0); // short run
        send(1, 2'h0);
        settle(2);
        chk(recv_loss_of_signal, 2'h3); // full run
        @(posedge clk);
        rx_line_bit <= 2'h3;
        settle(2);
        chk(rx_data_to_framer, 2'h0); // muted
        chk(rx_clock_to_framer, 2'(~rx_recovered_clock)); // clock kept
        wr(a_one, 8'h00, ok);
        settle(2);
        chk(rx_data_to_framer, 2'h3); // unmuted
        rd(a_stat, 8'h03, ok); // status
        send(1, 2'h3);
        settle(2);
        chk(recv_loss_of_signal, 2'h0); // cleared
        wr(a_one, 8'h02, ok);
        send(4095, 2'h0);
        settle(2);
        chk(recv_loss_of_signal, 2'h0); // short run
        send(1, 2'h0);
        settle(2);
        chk(recv_loss_of_signal, 2'h3); // full run
        send(1, 2'h3);
        done("loss of signal");
    endtask

    task t_clocks;
        integer c1, c2, p1, p2, et, ee;
        for (int s = 0; s < 4; s++) begin
            wr(a_three, 8'(s * 80), ok);
            rd(a_three, 8'(s * 80), ok); // readback
            settle(2);
            c1 = 0;
            c2 = 0;
            p1 = t1_master_clock_out;
            p2 = e1_master_clock_out;
            et = (1544 << s) / 50;
            ee = (2048 << s) / 50;
            repeat (5000) begin
                settle(1);
                c1 += (t1_master_clock_out && !p1);
                c2 += (e1_master_clock_out && !p2);
                p1 = t1_master_clock_out;
                p2 = e1_master_clock_out;
            end
            chk(c1 >= et && c1 <= et + 1, 1'b1); // edge count
            chk(c2 >= ee && c2 <= ee + 1, 1'b1); // edge count
        end
        done("master clocks");
    endtask

    task end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        settle(3);
        t_regs;
        t_gauge;
        t_term;
        t_los;
        t_clocks;
        end_of_test;
    end

    // Cuts a hang short well beyond the expected run
    initial begin
        #200000;
        err_total++;
        end_of_test;
    end
endmodule // lglc_top_bench
